/* File: psr_pkg.sv */
// shared constants and types of the processor status register bank
package psr_pkg;

  // status resource identifier layout
  localparam int          PSR_ID_SHIFT    = 8;
  localparam logic [7:0]  PSR_ID_TYPE     = 8'h0c;

  // register numbers
  localparam logic [7:0]  PSR_MEM_BASE    = 8'h00;
  localparam logic [7:0]  PSR_VEC_BASE    = 8'h01;
  localparam logic [7:0]  PSR_TILE_CTRL   = 8'h02;
  localparam logic [7:0]  PSR_BOOT_STATE  = 8'h03;
  localparam logic [7:0]  PSR_SEC_COPY    = 8'h05;
  localparam logic [7:0]  PSR_OSC_CTRL    = 8'h06;
  localparam logic [7:0]  PSR_OSC_CNT0    = 8'h07;
  localparam logic [7:0]  PSR_OSC_CNT_LST = 8'h0a;

  // values after reset
  localparam logic [31:0] PSR_MEM_BASE_RST = 32'h0001_0000;
  localparam logic [31:0] PSR_VEC_BASE_RST = 32'h0000_0000;

  // field positions
  localparam int PSR_MEM_LO       = 2;
  localparam int PSR_VEC_LO       = 16;
  localparam int PSR_DIV_EN_BIT   = 4;
  localparam int PSR_DIV_DYN_BIT  = 5;
  localparam int PSR_TILE_NUM_LO  = 16;
  localparam int PSR_OTP_BOOT_BIT = 8;
  localparam int PSR_OSC_TILE_BIT = 1;
  localparam int PSR_OSC_PER_BIT  = 0;

  // counts of cycles
  localparam logic [3:0]  PSR_DIV_RATIO   = 4'h4;
  localparam logic [1:0]  PSR_STRAP_SETTLE = 2'h2;

  localparam int PSR_NUM_OSC = 4;
  localparam int PSR_CNT_W   = 16;

  // request from the core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] res_id;
    logic [31:0] wdata;
  } psr_req_t;

  // answer to the core
  typedef struct packed {
    logic        rd_valid;
    logic        wr_ack;
    logic        err;
    logic [31:0] rdata;
  } psr_rsp_t;

  // state of one oscillator counter
  typedef struct packed {
    logic                 s1;
    logic                 s2;
    logic                 s3;
    logic [PSR_CNT_W-1:0] cnt;
  } psr_osc_state_t;

  // state of the bank
  typedef struct packed {
    logic [31:0] mem_base;
    logic [31:0] vec_base;
    logic        div_en;
    logic        div_dyn;
    logic [1:0]  osc_run;
    logic [7:0]  strap_s1;
    logic [7:0]  strap_s2;
    logic [7:0]  boot_mode;
    logic [1:0]  settle;
    logic [3:0]  div_cnt;
    logic        clk_tick;
    logic [31:0] event_addr;
    psr_rsp_t    rsp;
  } psr_state_t;

endpackage : psr_pkg

/* File: psr_osc_count.sv */
// one ring oscillator counter brought into the tile clock domain
`timescale 1ns/10ps
`default_nettype none

module psr_osc_count (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // oscillator
  input  wire logic                        osc_level,
  input  wire logic                        run,
  // count
  output var  logic [psr_pkg::PSR_CNT_W-1:0] count
);
  import psr_pkg::*;

  // zero power-up count, never cleared
  psr_osc_state_t st_reg = '0;
  psr_osc_state_t st_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = osc_level;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (run && st_reg.s2 && !st_reg.s3) begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
    if (sys_rst) begin
      st_reg.s1 <= 1'b0;
      st_reg.s2 <= 1'b0;
      st_reg.s3 <= 1'b0;
      st_reg.cnt <= st_reg.cnt;
    end
  end

  assign count = st_reg.cnt;

endmodule : psr_osc_count

`default_nettype wire

/* File: psr_bank.sv */
// processor status register bank of one tile
// What this block does
// - core reads and writes status registers by number via dedicated ops
// - memory base resets to 0x00010000
// - memory base bits 31:2 writable, bits 1:0 reserved read-only
// - event address is vector base 31:16 over event vector 15:0
// - control bit 4 enables clock divider, resets zero
// - bit 5 divides only while all active cores paused, else always
// - boot state bits 23:16 give tile number on switch
// - boot state bit 8 reads one when otp boot enabled
// - boot state bits 7:0 hold sampled boot strap pins
// - security copy register returns otp security word read-only
// - four oscillator counters read at four registers after control
// - oscillator control bit 1 runs tile oscillators, resets zero
// - oscillator control bit 0 runs peripheral oscillators, resets zero
// - counters 0x07..0x0a are tile cell, tile wire, periph cell, wire
// - counter registers return 16-bit count, upper bits zero
// - oscillator counters are not cleared by system reset
// - oscillators run asynchronously, usable as random bit source
`timescale 1ns/10ps
`default_nettype none

module psr_bank (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // status register access from the core
  input  wire psr_pkg::psr_req_t        ps_req,
  output var  psr_pkg::psr_rsp_t        ps_rsp,
  // boot and security inputs
  input  wire logic [7:0]               tile_number,
  input  wire logic                     otp_boot_en,
  input  wire logic [31:0]              otp_security_word,
  input  wire logic                     boot_strap_pin_0,
  input  wire logic                     boot_strap_pin_1,
  input  wire logic [5:0]               boot_strap_pin_hi,
  // event vectoring
  input  wire logic [15:0]              event_vector,
  output var  logic [31:0]              event_addr,
  // clock divider
  input  wire logic                     all_cores_paused,
  output var  logic                     tile_clk_tick,
  // memory base
  output var  logic [31:0]              mem_base,
  // ring oscillators
  output var  logic [1:0]               osc_run,
  input  wire logic [3:0]               osc_level
);
  import psr_pkg::*;

  psr_state_t st_reg;
  psr_state_t st_next;

  localparam psr_state_t PSR_RST = '{
    mem_base:   PSR_MEM_BASE_RST,
    vec_base:   PSR_VEC_BASE_RST,
    div_en:     1'b0,
    div_dyn:    1'b0,
    osc_run:    2'h0,
    strap_s1:   8'h00,
    strap_s2:   8'h00,
    boot_mode:  8'h00,
    settle:     2'h0,
    div_cnt:    4'h0,
    clk_tick:   1'b1,
    event_addr: 32'h0000_0000,
    rsp:        '0
  };

  logic [PSR_CNT_W-1:0] osc_cnt [PSR_NUM_OSC];
  logic [3:0]           osc_run_map;

  ////////////////////////////////////////////////////////////////////////
  // oscillator counters
  // order tile cell, tile wire, periph cell, periph wire
  assign osc_run_map = {st_reg.osc_run[PSR_OSC_PER_BIT],
                        st_reg.osc_run[PSR_OSC_PER_BIT],
                        st_reg.osc_run[PSR_OSC_TILE_BIT],
                        st_reg.osc_run[PSR_OSC_TILE_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < PSR_NUM_OSC; gi++) begin : g_osc
      psr_osc_count u_cnt (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .osc_level (osc_level[gi]),
        .run       (osc_run_map[gi]),
        .count     (osc_cnt[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // next state
  logic [7:0]  reg_num;
  logic        id_ok;
  logic        slowing;
  logic [31:0] rword;
  logic        mapped;
  logic [7:0]  cnt_idx;

  always_comb begin
    st_next = st_reg;
    rword   = 32'h0000_0000;
    mapped  = 1'b1;
    cnt_idx = 8'h00;

    st_next.strap_s1 = {boot_strap_pin_hi, boot_strap_pin_1,
                        boot_strap_pin_0};
    st_next.strap_s2 = st_reg.strap_s1;
    // latch straps once settled after reset
    if (st_reg.settle != PSR_STRAP_SETTLE) begin
      st_next.settle    = st_reg.settle + 2'h1;
      st_next.boot_mode = st_reg.strap_s2;
    end

    // number sits above the resource type byte
    reg_num = ps_req.res_id[PSR_ID_SHIFT +: 8];
    id_ok   = (ps_req.res_id[7:0] == PSR_ID_TYPE) &&
              (ps_req.res_id[31:16] == 16'h0000);

    case (reg_num)
      PSR_MEM_BASE: begin
        rword = st_reg.mem_base;
      end
      PSR_VEC_BASE: begin
        rword = st_reg.vec_base;
      end
      PSR_TILE_CTRL: begin
        rword[PSR_DIV_EN_BIT]  = st_reg.div_en;
        rword[PSR_DIV_DYN_BIT] = st_reg.div_dyn;
      end
      PSR_BOOT_STATE: begin
        rword[PSR_TILE_NUM_LO +: 8] = tile_number;
        rword[PSR_OTP_BOOT_BIT]     = otp_boot_en;
        rword[7:0]                  = st_reg.boot_mode;
      end
      PSR_SEC_COPY: begin
        rword = otp_security_word;
      end
      PSR_OSC_CTRL: begin
        rword[1:0] = st_reg.osc_run;
      end
      default: begin
        if (reg_num >= PSR_OSC_CNT0 && reg_num <= PSR_OSC_CNT_LST) begin
          cnt_idx = reg_num - PSR_OSC_CNT0;
          rword[PSR_CNT_W-1:0] = osc_cnt[cnt_idx[1:0]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase

    // answers are one-cycle pulses
    st_next.rsp          = '0;
    st_next.rsp.rdata    = st_reg.rsp.rdata;

    if (ps_req.rd) begin
      st_next.rsp.rd_valid = 1'b1;
      st_next.rsp.err      = !(id_ok && mapped);
      // reserved and unmapped read as zero
      st_next.rsp.rdata    = (id_ok && mapped) ? rword : 32'h0000_0000;
    end else if (ps_req.wr) begin
      st_next.rsp.wr_ack = 1'b1;
      st_next.rsp.err    = !(id_ok && mapped);
      if (id_ok) begin
        case (reg_num)
          PSR_MEM_BASE: begin
            st_next.mem_base = {ps_req.wdata[31:PSR_MEM_LO], 2'b00};
          end
          PSR_VEC_BASE: begin
            st_next.vec_base = {ps_req.wdata[31:PSR_VEC_LO], 16'h0000};
          end
          PSR_TILE_CTRL: begin
            st_next.div_en  = ps_req.wdata[PSR_DIV_EN_BIT];
            st_next.div_dyn = ps_req.wdata[PSR_DIV_DYN_BIT];
          end
          PSR_OSC_CTRL: begin
            st_next.osc_run[PSR_OSC_TILE_BIT] =
              ps_req.wdata[PSR_OSC_TILE_BIT];
            st_next.osc_run[PSR_OSC_PER_BIT] =
              ps_req.wdata[PSR_OSC_PER_BIT];
          end
          default: begin
            // read-only and unmapped numbers ignore writes
            st_next.rsp.wr_ack = 1'b1;
          end
        endcase
      end
    end

    st_next.event_addr = {st_reg.vec_base[31:PSR_VEC_LO], event_vector};

    // static always slows, dynamic only when all paused
    slowing = st_reg.div_en && (!st_reg.div_dyn || all_cores_paused);
    // divided tick while slowing, else every cycle
    if (!slowing) begin
      st_next.div_cnt  = 4'h0;
      st_next.clk_tick = 1'b1;
    end else if (st_reg.div_cnt == PSR_DIV_RATIO - 4'h1) begin
      st_next.div_cnt  = 4'h0;
      st_next.clk_tick = 1'b1;
    end else begin
      st_next.div_cnt  = st_reg.div_cnt + 4'h1;
      st_next.clk_tick = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= PSR_RST;
      st_reg.strap_s1 <= st_next.strap_s1;
      st_reg.strap_s2 <= st_next.strap_s2;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign ps_rsp        = st_reg.rsp;
  assign event_addr    = st_reg.event_addr;
  assign tile_clk_tick = st_reg.clk_tick;
  assign mem_base      = st_reg.mem_base;
  assign osc_run       = st_reg.osc_run;

endmodule : psr_bank

`default_nettype wire

/* File: psr_bank_assertions.sv */
// port assertions of the status register bank
`timescale 1ns/10ps
`default_nettype none

module psr_bank_chk (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  // core port
  input wire psr_pkg::psr_req_t ps_req,
  input wire psr_pkg::psr_rsp_t ps_rsp,
  // other ports
  input wire logic [31:0]       mem_base,
  input wire logic [15:0]       event_vector,
  input wire logic [31:0]       event_addr,
  input wire logic              tile_clk_tick,
  input wire logic [1:0]        osc_run
);
  import psr_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_rd_ans;
    ps_req.rd |=> ps_rsp.rd_valid && !ps_rsp.wr_ack;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_wr_ans;
    ps_req.wr && !ps_req.rd |=> ps_rsp.wr_ack && !ps_rsp.rd_valid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write not answered");
  property p_err;
    ps_rsp.err |-> ps_rsp.rd_valid || ps_rsp.wr_ack;
  endproperty
  a_err: assert property (p_err)
    else $error("error without answer");
  property p_mem_rst;
    $past(sys_rst) |-> mem_base == PSR_MEM_BASE_RST;
  endproperty
  a_mem_rst: assert property (p_mem_rst)
    else $error("memory base reset value");
  property p_mem_wr;
    $changed(mem_base) |-> $past(ps_req.wr) && mem_base[1:0] == 2'h0;
  endproperty
  a_mem_wr: assert property (p_mem_wr)
    else $error("memory base changed badly");
  property p_evt;
    !$past(sys_rst) |-> event_addr[15:0] == $past(event_vector);
  endproperty
  a_evt: assert property (p_evt)
    else $error("event address low half");
  property p_tick;
    !tile_clk_tick [*3] |=> tile_clk_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick gap too long");
  property p_osc_rst;
    $past(sys_rst) |-> osc_run == 2'h0;
  endproperty
  a_osc_rst: assert property (p_osc_rst)
    else $error("run bits not reset");
  property p_osc_wr;
    $changed(osc_run) |-> $past(ps_req.wr);
  endproperty
  a_osc_wr: assert property (p_osc_wr)
    else $error("run bits changed without write");

  c_err: cover property (ps_rsp.rd_valid && ps_rsp.err);
  c_slow: cover property (!tile_clk_tick [*3]);
  c_run: cover property (osc_run == 2'h3);
endmodule : psr_bank_chk

bind psr_bank psr_bank_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .ps_req(ps_req), .ps_rsp(ps_rsp), .mem_base(mem_base),
  .event_vector(event_vector), .event_addr(event_addr),
  .tile_clk_tick(tile_clk_tick), .osc_run(osc_run));
`default_nettype wire

/* File: psr_core_model.sv */
// model of the core issuing status register accesses
`timescale 1ns/10ps
`default_nettype none

module psr_core_model (
  // clock
  input  wire logic              clk_sys,
  // status register port
  output var  psr_pkg::psr_req_t ps_req,
  input  wire psr_pkg::psr_rsp_t ps_rsp
);
  import psr_pkg::*;
  initial ps_req = '0;
  function automatic logic [31:0] rid(input logic [7:0] num);
    return (32'(num) << PSR_ID_SHIFT) | 32'(PSR_ID_TYPE);
  endfunction : rid
  task automatic xfer(input logic r, input logic [31:0] id, wd,
                      output logic [31:0] dat, output logic e);
    @(negedge clk_sys);
    ps_req <= '{rd: r, wr: !r, res_id: id, wdata: wd};
    @(negedge clk_sys);
    // released lines show the inverse
    ps_req <= '{rd: 1'b0, wr: 1'b0, res_id: ~id, wdata: ~wd};
    for (int i = 0; i < 2 && (ps_rsp.rd_valid | ps_rsp.wr_ack) !== 1'b1; i++)
      @(negedge clk_sys);
    dat = ps_rsp.rdata;
    e = ps_rsp.err;
  endtask : xfer
endmodule : psr_core_model
`default_nettype wire

/* File: psr_bank_tb.sv */
// self-checking bench of the status register bank
`timescale 1ns/10ps
`default_nettype none

module psr_bank_tb;
  import psr_pkg::*;
  logic        clk_sys, sys_rst, otp_boot_en, paused, tick, er;
  logic [7:0]  tile_number, straps;
  logic [15:0] event_vector;
  logic [31:0] otp_word, event_addr, mem_base, rnd, rdat, c0 [4];
  logic [3:0]  osc_level;
  logic [1:0]  osc_run;
  logic [15:0] dl [4] = '{16'h7, 16'h4, 16'h5, 16'h2};
  logic [31:0] bad [4] = '{32'h40c, 32'hb0c, 32'hd, 32'h1000c};
  psr_req_t    ps_req;
  psr_rsp_t    ps_rsp;
  int          bad_count = 0, checked = 0, cyc = 0, n;

  psr_bank i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ps_req(ps_req),
    .ps_rsp(ps_rsp), .tile_number(tile_number), .otp_boot_en(otp_boot_en),
    .otp_security_word(otp_word), .boot_strap_pin_0(straps[0]),
    .boot_strap_pin_1(straps[1]), .boot_strap_pin_hi(straps[7:2]),
    .event_vector(event_vector), .event_addr(event_addr),
    .all_cores_paused(paused), .tile_clk_tick(tick),
    .mem_base(mem_base), .osc_run(osc_run), .osc_level(osc_level));
  psr_core_model i_core (.clk_sys(clk_sys), .ps_req(ps_req), .ps_rsp(ps_rsp));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] num);
    i_core.xfer(1'b1, i_core.rid(num), 32'h0, rdat, er);
    chk({31'h0, ps_rsp.rd_valid}, 32'h1);
  endtask : rd
  task automatic wr(input logic [7:0] num, input logic [31:0] d);
    i_core.xfer(1'b0, i_core.rid(num), d, rdat, er);
    chk({31'h0, ps_rsp.wr_ack}, 32'h1);
  endtask : wr
  task automatic rdc(input logic [7:0] num, input logic [31:0] exp);
    rd(num);
    chk(rdat, exp);
    chk({31'h0, er}, 32'h0);
  endtask : rdc
  task automatic pulse(input logic [3:0] m, input int k);
    repeat (k) begin
      @(negedge clk_sys) osc_level <= m;
      repeat (3) @(negedge clk_sys);
      osc_level <= 4'h0;
      repeat (3) @(negedge clk_sys);
    end
  endtask : pulse
  task automatic ticks(input logic [31:0] exp);
    n = 0;
    repeat (4) @(negedge clk_sys);
    repeat (40) @(negedge clk_sys) n += (tick === 1'b1);
    chk(32'(n), exp);
  endtask : ticks
  task automatic finish_test();
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    rnd = 32'h2e;
    {tile_number, straps, event_vector} = 32'h5ac3_0000 | rnd;
    otp_word = lfsr(rnd);
    otp_boot_en = 1'b1;
    paused = 1'b0;
    osc_level = 4'h0;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    rdc(PSR_MEM_BASE, PSR_MEM_BASE_RST);
    rdc(PSR_TILE_CTRL, 32'h0);
    rdc(PSR_OSC_CTRL, 32'h0);
    rdc(PSR_BOOT_STATE,
        {8'h0, tile_number, 7'h0, otp_boot_en, straps});
    wr(PSR_SEC_COPY, ~otp_word);
    rdc(PSR_SEC_COPY, otp_word);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr(PSR_MEM_BASE, rnd);
      rdc(PSR_MEM_BASE, rnd & 32'hfffffffc);
      chk(mem_base, rnd & 32'hfffffffc);
      wr(PSR_VEC_BASE, rnd);
      event_vector = rnd[15:0];
      rdc(PSR_VEC_BASE, rnd & 32'hffff0000);
      chk(event_addr, rnd);
    end
    foreach (bad[i]) begin
      i_core.xfer(1'b1, bad[i], 32'h0, rdat, er);
      chk(rdat, 32'h0);
      chk({31'h0, er}, 32'h1);
    end
    wr(PSR_TILE_CTRL, 32'hffffffff);
    rdc(PSR_TILE_CTRL, 32'h30);
    ticks(40);
    paused = 1'b1;
    ticks(10);
    wr(PSR_TILE_CTRL, 32'h10);
    paused = 1'b0;
    ticks(10);
    wr(PSR_TILE_CTRL, 32'h0);
    ticks(40);
    wr(PSR_OSC_CTRL, 32'hffffffff);
    rdc(PSR_OSC_CTRL, 32'h3);
    chk({30'h0, osc_run}, 32'h3);
    pulse(4'hf, 1);
    wr(PSR_OSC_CTRL, 32'h0);
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      rd(PSR_OSC_CNT0 + 8'(i));
      c0[i] = rdat;
    end
    wr(PSR_OSC_CTRL, 32'h2);
    pulse(4'hf, 1);
    wr(PSR_OSC_CTRL, 32'h3);
    pulse(4'hf, 2);
    pulse(4'h5, 3);
    pulse(4'h3, 1);
    wr(PSR_OSC_CTRL, 32'h0);
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b1;
    straps = ~straps;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    rdc(PSR_MEM_BASE, PSR_MEM_BASE_RST);
    rdc(PSR_BOOT_STATE,
        {8'h0, tile_number, 7'h0, otp_boot_en, straps});
    for (int i = 0; i < 4; i++) begin
      rd(PSR_OSC_CNT0 + 8'(i));
      chk(rdat, {16'h0, c0[i][15:0] + dl[i]});
    end
    finish_test();
  end
endmodule : psr_bank_tb
`default_nettype wire
